/* verilog/bldc_pkg.sv */
// constants, types and register map of the sensorless commutation block
// assumes one 200 MHz clock and a classic wishbone master
package bldc_pkg;
  localparam longint CLK_HZ = 200_000_000;
  localparam longint NS_PER_S = 1_000_000_000;
  localparam longint SEC_PER_MIN = 60;
  localparam longint STEPS_FACTOR = 6;
  localparam longint INSTR_DIV = 4;
  localparam longint TMR_PRESCALE = 8;
  localparam int POLE_PAIRS = 5;
  localparam longint RPM_LOW = 400;
  localparam longint RPM_HIGH = 900;
  localparam logic [15:0] TMR_TOP = 16'hffff;
  localparam logic [4:0] TICK_DIV_M1 = 5'(INSTR_DIV * TMR_PRESCALE - 1);
  localparam logic [7:0] LOW_STAGE_STEPS = 8'h30;
  localparam logic [4:0] SYNC_CYCLES = 5'h10;
  localparam logic [15:0] FILT_TH_MID = 16'h0800;
  localparam logic [15:0] FILT_TH_SLOW = 16'h2000;
  localparam logic [15:0] THIRD_Q16 = 16'h5556;
  // register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_OL_DUTY = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_IRQ_STATUS = 8'h0c;
  localparam logic [7:0] REG_IRQ_MASK = 8'h10;
  localparam logic [7:0] REG_SPEED = 8'h14;
  // reset values
  localparam logic [2:0] CTRL_PSC_RST = 3'h1;
  localparam logic [9:0] OL_DUTY_RST = 10'h100;
  localparam logic [3:0] IRQ_MASK_RST = 4'h0;
  // interrupt bit positions
  localparam int IRQ_COMMUTE = 0;
  localparam int IRQ_FAULT = 1;
  localparam int IRQ_LOCKED = 2;
  localparam int IRQ_LOST = 3;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_LOW = 3'b001,
    ST_HIGH = 3'b010,
    ST_CLOSED = 3'b011,
    ST_FAULT = 3'b100
  } motor_state_t;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } wb_req_t;

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } wb_rsp_t;

  typedef struct packed {
    logic [5:0] gate;
    logic [9:0] duty;
  } bridge_drive_t;

  // step reload: top minus step time times fosc/4, counted in prescaled ticks
  function automatic logic [15:0] step_reload(input longint rpm);
    longint step_ns;
    step_ns = SEC_PER_MIN * NS_PER_S / (rpm * POLE_PAIRS * STEPS_FACTOR);
    return 16'(longint'(TMR_TOP) - step_ns * (CLK_HZ / INSTR_DIV / TMR_PRESCALE) / NS_PER_S);
  endfunction : step_reload
endpackage : bldc_pkg

/* verilog/zero_cross_filter.sv */
// digital low-pass filter for the three zero-cross comparator inputs
// assumes raw asynchronous pins; level and prescale come from the same clock
`timescale 1ns/10ps
module zero_cross_filter #(
  parameter int BASE_LEN = 2
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_b_i,
  // settings
  input wire logic [2:0] psc_i,
  input wire logic [1:0] level_i,
  // comparators in, filtered out
  input wire logic [2:0] zc_raw_i,
  output logic [2:0] zc_o
);
  import bldc_pkg::*;

  typedef struct packed {
    logic [2:0] s1;
    logic [2:0] s2;
    logic [6:0] pre;
    logic [2:0][5:0] cnt;
    logic [2:0] out;
  } filt_state_t;

  filt_state_t st_ff;
  filt_state_t nxt_st;
  logic pre_tick;
  logic [5:0] need;

  // prescaler tick: 2^psc clocks per sample
  assign pre_tick = (st_ff.pre & ((7'h01 << psc_i) - 7'h01)) == 7'h00;
  assign need = 6'(BASE_LEN << (2 * level_i));

  // a channel follows its input only after it stood still long enough
  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.s1 = zc_raw_i;
    nxt_st.s2 = st_ff.s1;
    nxt_st.pre = st_ff.pre + 7'h01;
    for (int i = 0; i < 3; i++)
    begin
      if (st_ff.s2[i] == st_ff.out[i])
        nxt_st.cnt[i] = 6'h00;
      else if (pre_tick)
      begin
        if (st_ff.cnt[i] + 6'h01 >= need)
        begin
          nxt_st.out[i] = st_ff.s2[i];
          nxt_st.cnt[i] = 6'h00;
        end
        else
          nxt_st.cnt[i] = st_ff.cnt[i] + 6'h01;
      end
    end
  end

  // state register
  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      st_ff <= '0;
    else
      st_ff <= nxt_st;
  end

  assign zc_o = st_ff.out;
endmodule : zero_cross_filter

/* verilog/sensorless_bldc_commutation.sv */
// sensorless six-step commutation controller with wishbone registers
// assumes async switch, fault and comparator pins, adc sample on mclk_i
// What this block does
// - A low level on the overcurrent pin is an active fault.
// - The direction switch reverses the pattern order and the run switch starts or stops the drive.
// - The speed demand is taken from the adc sample of the speed reference channel.
// - Start-up runs open loop and the loop closes on zero-cross inputs once back-emf is usable.
// - Open loop runs a low-speed stage first and then a high-speed stage.
// - In open loop the step timer paces the patterns at a fixed speed.
// - The step period is 60 over rpm times pole pairs times 6.
// - The timer reload is ffffh minus step time times fosc over 32 (fosc over 4, then a prescale of 8).
// - Each timer overflow loads the next pattern, reloads the timer and loads a duty value.
// - At high start-up speed the zero-cross signals are watched for 16 crossings (both edges) of the first input before closing the loop.
// - In closed loop a zero-cross starts a 60-degree delay whose end writes the next pattern.
// - Only the first capture input resynchronises timing, on both its edges.
// - In closed loop the pattern is chosen from the state of all three capture inputs.
// - Zero-cross inputs are digitally filtered with a prescaler and one of three speed-chosen levels.
// - The pattern changes every 60 electrical degrees, six patterns per cycle.
//
// Added by the designer: the Wishbone register port and the register offsets.
`timescale 1ns/10ps
module sensorless_bldc_commutation #(
  parameter logic [15:0] RELOAD_LOW = bldc_pkg::step_reload(bldc_pkg::RPM_LOW),
  parameter logic [15:0] RELOAD_HIGH = bldc_pkg::step_reload(bldc_pkg::RPM_HIGH)
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_b_i,
  // wishbone slave
  input wire bldc_pkg::wb_req_t wb_req_i,
  output bldc_pkg::wb_rsp_t wb_rsp_o,
  output logic irq_o,
  // operator pins
  input wire logic run_stop_switch_i,
  input wire logic direction_switch_i,
  input wire logic overcurrent_fault_b_i,
  // speed reference adc sample
  input wire logic [9:0] speed_reference_channel_i,
  input wire logic speed_reference_valid_i,
  // comparators and bridge
  input wire logic [2:0] back_emf_zero_cross_i,
  output bldc_pkg::bridge_drive_t bridge_o
);
  import bldc_pkg::*;

  typedef struct packed {
    logic run_s1;
    logic run_s2;
    logic dir_s1;
    logic dir_s2;
    logic flt_s1;
    logic flt_s2;
    logic run_prev;
    logic ctrl_en;
    logic [2:0] psc;
    logic [9:0] ol_duty;
    logic [3:0] irq_st;
    logic [3:0] irq_mask;
    logic irq;
    wb_rsp_t rsp;
    motor_state_t mst;
    logic [2:0] step;
    bridge_drive_t drive;
    logic [4:0] presc;
    logic [15:0] tmr;
    logic [7:0] ol_count;
    logic [4:0] sync_count;
    logic [15:0] interval;
    logic [15:0] half_period;
    logic [15:0] delay;
    logic zca_prev;
    logic [9:0] speed_ref;
  } ctl_state_t;

  ctl_state_t st_ff;
  ctl_state_t nxt_st;
  logic [2:0] zc_f;
  logic [1:0] filt_level;
  logic tick;
  logic run_cond;
  logic ovf;
  logic zca_edge;
  logic [2:0] zc_step;
  logic [31:0] period_prod;
  logic [15:0] step_period;
  logic [3:0] irq_set;
  logic bus_hit;
  logic [31:0] wmask;
  logic [31:0] ctrl_word;

  // ---------------------------------------------------------------
  // pattern helpers
  // ---------------------------------------------------------------
  // gate order {ah, al, bh, bl, ch, cl}
  function automatic logic [5:0] step_pattern(input logic [2:0] s);
    case (s)
      3'h0: return 6'h21;
      3'h1: return 6'h09;
      3'h2: return 6'h18;
      3'h3: return 6'h12;
      3'h4: return 6'h06;
      3'h5: return 6'h24;
      default: return 6'h00;
    endcase
  endfunction : step_pattern

  function automatic logic [2:0] step_adv(input logic [2:0] s, input logic fwd);
    if (fwd)
      return (s == 3'h5) ? 3'h0 : s + 3'h1;
    else
      return (s == 3'h0) ? 3'h5 : s - 3'h1;
  endfunction : step_adv

  // rotor state from all three comparators; 7 marks an illegal code
  function automatic logic [2:0] zc_decode(input logic [2:0] zc, input logic fwd);
    logic [2:0] f;
    case (zc)
      3'b101: f = 3'h0;
      3'b100: f = 3'h1;
      3'b110: f = 3'h2;
      3'b010: f = 3'h3;
      3'b011: f = 3'h4;
      3'b001: f = 3'h5;
      default: f = 3'h7;
    endcase
    if (f == 3'h7 || fwd)
      return f;
    else
      return (f >= 3'h3) ? f - 3'h3 : f + 3'h3;
  endfunction : zc_decode

  // ---------------------------------------------------------------
  // zero-cross filter
  // ---------------------------------------------------------------
  // slower motor gets a longer filter
  assign filt_level = (st_ff.half_period > FILT_TH_SLOW) ? 2'h2 :
                      (st_ff.half_period > FILT_TH_MID) ? 2'h1 : 2'h0;

  zero_cross_filter #(
    .BASE_LEN(2)
  ) u_filter (
    .mclk_i(mclk_i),
    .rst_b_i(rst_b_i),
    .psc_i(st_ff.psc),
    .level_i(filt_level),
    .zc_raw_i(back_emf_zero_cross_i),
    .zc_o(zc_f)
  );

  // ---------------------------------------------------------------
  // derived terms
  // ---------------------------------------------------------------
  // fault pin is active low, run needs switch and software enable
  assign run_cond = st_ff.run_s2 & st_ff.ctrl_en;
  assign tick = st_ff.presc == 5'h00;
  assign ovf = tick & (st_ff.tmr == TMR_TOP);
  assign zca_edge = zc_f[0] ^ st_ff.zca_prev;
  assign zc_step = zc_decode(zc_f, st_ff.dir_s2);
  // a half cycle holds three steps, so a step is a third of it
  assign period_prod = st_ff.half_period * THIRD_Q16;
  assign step_period = period_prod[31:16];
  assign bus_hit = wb_req_i.cyc & wb_req_i.stb & ~st_ff.rsp.ack;
  assign wmask = {{8{wb_req_i.sel[3]}}, {8{wb_req_i.sel[2]}},
                  {8{wb_req_i.sel[1]}}, {8{wb_req_i.sel[0]}}};
  assign ctrl_word = {28'h0000000, st_ff.psc, st_ff.ctrl_en};

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb
  begin
    nxt_st = st_ff;
    irq_set = 4'h0;
    // two-stage sync of operator pins
    nxt_st.run_s1 = run_stop_switch_i;
    nxt_st.run_s2 = st_ff.run_s1;
    nxt_st.dir_s1 = direction_switch_i;
    nxt_st.dir_s2 = st_ff.dir_s1;
    nxt_st.flt_s1 = ~overcurrent_fault_b_i;
    nxt_st.flt_s2 = st_ff.flt_s1;
    nxt_st.run_prev = run_cond;
    nxt_st.zca_prev = zc_f[0];
    nxt_st.presc = tick ? TICK_DIV_M1 : st_ff.presc - 5'h01;
    if (speed_reference_valid_i)
      nxt_st.speed_ref = speed_reference_channel_i;

    // motor sequencer
    case (st_ff.mst)
      ST_IDLE:
      begin
        nxt_st.drive.gate = 6'h00;
        if (run_cond & ~st_ff.run_prev)
        begin
          nxt_st.mst = ST_LOW;
          nxt_st.tmr = RELOAD_LOW;
          nxt_st.ol_count = 8'h00;
          nxt_st.sync_count = 5'h00;
          nxt_st.half_period = 16'h0000;
          nxt_st.step = 3'h0;
          nxt_st.drive.gate = step_pattern(3'h0);
          nxt_st.drive.duty = st_ff.ol_duty;
        end
      end
      ST_LOW, ST_HIGH:
      begin
        if (tick)
          nxt_st.tmr = st_ff.tmr + 16'h0001;
        if (tick)
          nxt_st.interval = (st_ff.interval == TMR_TOP) ? TMR_TOP : st_ff.interval + 16'h0001;
        if (ovf)
        begin
          // next pattern, reload and duty on every overflow
          nxt_st.step = step_adv(st_ff.step, st_ff.dir_s2);
          nxt_st.drive.gate = step_pattern(nxt_st.step);
          nxt_st.drive.duty = st_ff.ol_duty;
          nxt_st.tmr = (st_ff.mst == ST_LOW) ? RELOAD_LOW : RELOAD_HIGH;
          irq_set[IRQ_COMMUTE] = 1'b1;
          if (st_ff.mst == ST_LOW)
          begin
            nxt_st.ol_count = st_ff.ol_count + 8'h01;
            if (st_ff.ol_count == LOW_STAGE_STEPS - 8'h01)
              nxt_st.mst = ST_HIGH;
          end
        end
        // at high speed, count aligned zero-crossings before closing
        if (st_ff.mst == ST_HIGH && zca_edge)
        begin
          nxt_st.interval = 16'h0000;
          nxt_st.half_period = st_ff.interval;
          if (zc_step == st_ff.step || zc_step == step_adv(st_ff.step, st_ff.dir_s2))
            nxt_st.sync_count = st_ff.sync_count + 5'h01;
          else
            nxt_st.sync_count = 5'h00;
          if (st_ff.sync_count == SYNC_CYCLES - 5'h01)
          begin
            nxt_st.mst = ST_CLOSED;
            nxt_st.delay = step_period;
            irq_set[IRQ_LOCKED] = 1'b1;
          end
        end
      end
      ST_CLOSED:
      begin
        if (tick)
          nxt_st.interval = (st_ff.interval == TMR_TOP) ? TMR_TOP : st_ff.interval + 16'h0001;
        if (tick && st_ff.delay != 16'h0000)
          nxt_st.delay = st_ff.delay - 16'h0001;
        if (tick && st_ff.delay == 16'h0001)
        begin
          // 60 degrees after the crossing: next pattern
          nxt_st.step = step_adv((zc_step == 3'h7) ? st_ff.step : zc_step, st_ff.dir_s2);
          nxt_st.drive.gate = step_pattern(nxt_st.step);
          nxt_st.drive.duty = st_ff.speed_ref;
          nxt_st.delay = step_period;
          irq_set[IRQ_COMMUTE] = 1'b1;
        end
        if (zca_edge)
        begin
          // resync on both edges of the first input
          nxt_st.interval = 16'h0000;
          nxt_st.half_period = st_ff.interval;
          nxt_st.delay = step_period;
        end
        if (st_ff.interval == TMR_TOP)
        begin
          nxt_st.mst = ST_IDLE;
          nxt_st.drive.gate = 6'h00;
          irq_set[IRQ_LOST] = 1'b1;
        end
      end
      ST_FAULT:
      begin
        nxt_st.drive.gate = 6'h00;
        if (!st_ff.flt_s2)
          nxt_st.mst = ST_IDLE;
      end
      default:
      begin
        nxt_st.mst = ST_IDLE;
        nxt_st.drive.gate = 6'h00;
      end
    endcase

    // stop and fault override everything above
    if (st_ff.mst != ST_FAULT && st_ff.mst != ST_IDLE && !run_cond)
    begin
      nxt_st.mst = ST_IDLE;
      nxt_st.drive.gate = 6'h00;
    end
    if (st_ff.flt_s2)
    begin
      nxt_st.mst = ST_FAULT;
      nxt_st.drive.gate = 6'h00;
      if (st_ff.mst != ST_FAULT)
        irq_set[IRQ_FAULT] = 1'b1;
    end

    // wishbone slave: one-cycle ack, read data with it
    nxt_st.rsp.ack = bus_hit;
    nxt_st.rsp.dat = 32'h00000000;
    if (bus_hit && wb_req_i.we)
    begin
      case (wb_req_i.adr)
        REG_CTRL:
        begin
          nxt_st.ctrl_en = (ctrl_word[0] & ~wmask[0]) | (wb_req_i.dat[0] & wmask[0]);
          if (wb_req_i.sel[0])
            nxt_st.psc = wb_req_i.dat[3:1];
        end
        REG_OL_DUTY:
          nxt_st.ol_duty = (st_ff.ol_duty & ~wmask[9:0]) | (wb_req_i.dat[9:0] & wmask[9:0]);
        REG_IRQ_MASK:
          if (wb_req_i.sel[0])
            nxt_st.irq_mask = wb_req_i.dat[3:0];
        default:
          nxt_st.rsp.dat = 32'h00000000;
      endcase
    end
    if (bus_hit && !wb_req_i.we)
    begin
      case (wb_req_i.adr)
        REG_CTRL: nxt_st.rsp.dat = ctrl_word;
        REG_OL_DUTY: nxt_st.rsp.dat = {22'h000000, st_ff.ol_duty};
        REG_STATUS: nxt_st.rsp.dat = {20'h00000, filt_level, st_ff.flt_s2,
                                      st_ff.dir_s2, 1'b0, st_ff.step, 1'b0, st_ff.mst};
        REG_IRQ_STATUS: nxt_st.rsp.dat = {28'h0000000, st_ff.irq_st};
        REG_IRQ_MASK: nxt_st.rsp.dat = {28'h0000000, st_ff.irq_mask};
        REG_SPEED: nxt_st.rsp.dat = {st_ff.speed_ref, 6'h00, st_ff.half_period};
        default: nxt_st.rsp.dat = 32'h00000000;
      endcase
    end

    // sticky events: a read clears, a new event in that cycle wins
    if (bus_hit && !wb_req_i.we && wb_req_i.adr == REG_IRQ_STATUS)
      nxt_st.irq_st = irq_set;
    else
      nxt_st.irq_st = st_ff.irq_st | irq_set;
    nxt_st.irq = |(nxt_st.irq_st & nxt_st.irq_mask);
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      st_ff <= '0;
      st_ff.psc <= CTRL_PSC_RST;
      st_ff.ol_duty <= OL_DUTY_RST;
      st_ff.irq_mask <= IRQ_MASK_RST;
      st_ff.presc <= TICK_DIV_M1;
    end
    else
      st_ff <= nxt_st;
  end

  // outputs straight from the state register
  assign wb_rsp_o = st_ff.rsp;
  assign irq_o = st_ff.irq;
  assign bridge_o = st_ff.drive;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  sequence seq_start;
    st_ff.mst == ST_IDLE ##1 st_ff.mst != ST_IDLE;
  endsequence

  sequence seq_lock;
    st_ff.mst == ST_HIGH ##1 st_ff.mst == ST_CLOSED;
  endsequence

  AST_FAULT_GATES_OFF: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    st_ff.flt_s2 |=> bridge_o.gate == 6'h00 && st_ff.mst == ST_FAULT)
    else $error("gates not off after fault");

  AST_FAULT_NO_RESTART: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    st_ff.mst == ST_FAULT |=> st_ff.mst inside {ST_FAULT, ST_IDLE})
    else $error("left fault without passing idle");

  AST_STOP_DRIVE: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    !run_cond |=> bridge_o.gate == 6'h00)
    else $error("drive active while stopped");

  AST_SPEED_SAMPLE: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    speed_reference_valid_i |=> st_ff.speed_ref == $past(speed_reference_channel_i))
    else $error("speed sample not taken");

  AST_START_OPEN: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    seq_start |-> st_ff.mst inside {ST_LOW, ST_FAULT})
    else $error("start not in open loop");

  AST_OVF_STEP: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    ovf && st_ff.mst == ST_LOW && run_cond && !st_ff.flt_s2 |=>
      st_ff.tmr == RELOAD_LOW && st_ff.step == step_adv($past(st_ff.step), $past(st_ff.dir_s2))
      && bridge_o.duty == $past(st_ff.ol_duty))
    else $error("overflow did not reload and advance");

  AST_SYNC_COUNT: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    seq_lock |-> $past(st_ff.sync_count) == SYNC_CYCLES - 5'h01)
    else $error("loop closed without sixteen crossings");

  AST_DELAY_COMMUTE: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    st_ff.mst == ST_CLOSED && tick && st_ff.delay == 16'h0001 && run_cond && !st_ff.flt_s2
      && st_ff.interval != TMR_TOP |=> bridge_o.gate == step_pattern(st_ff.step))
    else $error("no commutation at end of delay");

  AST_IRQ_LEVEL: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    irq_o == |(st_ff.irq_st & st_ff.irq_mask))
    else $error("interrupt level mismatch");
endmodule : sensorless_bldc_commutation

/* verification/bridge_bemf_model.sv */
// partner model: inverter bridge driving a turning rotor and its three comparators
// assumes gate patterns come registered on mclk_i; the rotor follows them after LAG clocks
`timescale 1ns/10ps
module bridge_bemf_model #(
  parameter int LAG = 20
) (
  // clock
  input wire logic mclk_i,
  // bridge side
  input wire logic [5:0] gate_i,
  input wire logic dir_i,
  // comparators {c,b,a}
  output logic [2:0] zc_o
);
  // energizing patterns and comparator levels, step 0 in the low bits
  localparam logic [35:0] PATS = {6'h24, 6'h06, 6'h12, 6'h18, 6'h09, 6'h21};
  localparam logic [17:0] CODES = {3'b001, 3'b011, 3'b010, 3'b110, 3'b100, 3'b101};
  logic [5:0] seen_ff = '0;
  int wait_ff = 0;
  int idx;
  initial zc_o = 3'h0;
  // after the lag the open phase crosses neutral; the comparator rises on a
  // positive crossing and falls on a negative one
  always @(posedge mclk_i)
  begin
    idx = 0;
    for (int i = 0; i < 6; i++)
      if (gate_i == PATS[6*i +: 6]) idx = dir_i ? i : (i + 3) % 6;
    if (gate_i != seen_ff)
    begin
      seen_ff <= gate_i;
      wait_ff <= LAG;
    end
    else if (wait_ff > 0)
      wait_ff <= wait_ff - 1;
    else
      zc_o <= (gate_i == 6'h00) ? 3'h0 : CODES[3*idx +: 3];
  end
endmodule : bridge_bemf_model

/* verification/sensorless_bldc_commutation_tb.sv */
// self-checking bench for the sensorless commutation block
// assumes the bridge model closes the loop; short reload values keep the run brief
`timescale 1ns/10ps
module sensorless_bldc_commutation_tb;
  import bldc_pkg::*;
  typedef struct packed {logic we; logic [7:0] adr; logic [3:0] sel; logic [31:0] dat; logic [31:0] exp;} row_t;
  localparam logic [15:0] RL = 16'hfff0;
  localparam logic [15:0] RH = 16'hfff8;
  localparam logic [35:0] PATS = {6'h24, 6'h06, 6'h12, 6'h18, 6'h09, 6'h21};
  logic mclk_i = 1'b0, rst_b_i = 1'b0, run = 1'b0, dir = 1'b1, flt_b = 1'b1, spd_v = 1'b0;
  logic [9:0] spd = '0;
  logic [2:0] zc;
  logic irq;
  logic [31:0] q;
  wb_req_t req = '0;
  wb_rsp_t rsp;
  bridge_drive_t br;
  int n_fail = 0, tests_run = 0, cyc_cnt = 0, n;
  row_t rows [10] = '{
    '{1'b0, REG_CTRL, 4'hf, 32'h0, 32'h2}, '{1'b0, REG_OL_DUTY, 4'hf, 32'h0, 32'h100},
    '{1'b0, REG_IRQ_MASK, 4'hf, 32'h0, 32'h0}, '{1'b0, REG_IRQ_STATUS, 4'hf, 32'h0, 32'h0},
    '{1'b1, 8'h18, 4'hf, 32'h5a5a, 32'h0}, '{1'b0, 8'h18, 4'hf, 32'h0, 32'h0},
    '{1'b1, REG_OL_DUTY, 4'h1, 32'h3ff, 32'h0}, '{1'b0, REG_OL_DUTY, 4'hf, 32'h0, 32'h1ff},
    '{1'b1, REG_CTRL, 4'hf, 32'h3, 32'h0}, '{1'b0, REG_CTRL, 4'hf, 32'h0, 32'h3}};

  sensorless_bldc_commutation #(.RELOAD_LOW(RL), .RELOAD_HIGH(RH)) dut (.mclk_i(mclk_i), .rst_b_i(rst_b_i),
    .wb_req_i(req), .wb_rsp_o(rsp), .irq_o(irq), .run_stop_switch_i(run), .direction_switch_i(dir),
    .overcurrent_fault_b_i(flt_b), .speed_reference_channel_i(spd), .speed_reference_valid_i(spd_v),
    .back_emf_zero_cross_i(zc), .bridge_o(br));
  bridge_bemf_model model (.mclk_i(mclk_i), .gate_i(br.gate), .dir_i(dir), .zc_o(zc));

  initial forever #2.5 mclk_i = ~mclk_i;
  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // classic single wishbone cycle, held until ack is sampled
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    int k;
    k = 0;
    @(posedge mclk_i);
    req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: s, dat: d};
    do begin @(posedge mclk_i); k++; end while (rsp.ack !== 1'b1 && k < 50);
    q = rsp.dat;
    req <= '0;
    if (k >= 50) chk(32'h1, 32'h0);
  endtask : wb
  // cycles until the gate pattern changes
  task automatic gate_move();
    logic [5:0] old;
    old = br.gate;
    n = 0;
    do begin @(posedge mclk_i); n++; end while (br.gate === old && n < 20000);
  endtask : gate_move
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : end_sim
  // hang guard
  always @(posedge mclk_i)
  begin
    cyc_cnt++;
    if (cyc_cnt == 90000) begin n_fail++; end_sim(); end
  end
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial
  begin
    repeat (16) @(posedge mclk_i);
    rst_b_i <= 1'b1;
    chk({16'h0, br}, 32'h0);
    foreach (rows[i])
    begin
      wb(rows[i].we, rows[i].adr, rows[i].dat, rows[i].sel);
      if (!rows[i].we) chk(q, rows[i].exp);
    end
    spd <= 10'h2a5;
    spd_v <= 1'b1;
    @(posedge mclk_i) spd_v <= 1'b0;
    wb(1'b0, REG_SPEED, 32'h0, 4'hf);
    chk(q >> 22, 32'h2a5);
    // open-loop start, step pacing and duty
    run <= 1'b1;
    gate_move();
    chk({16'h0, br}, {16'h0, 6'h21, 10'h1ff});
    wb(1'b0, REG_STATUS, 32'h0, 4'hf);
    chk(q & 32'h7, 32'h1);
    gate_move();
    chk(br.gate, 6'h09);
    gate_move();
    chk(n, (32'h10000 - RL) * 32);
    chk(irq, 1'b0);
    wb(1'b1, REG_IRQ_MASK, 32'h1, 4'hf);
    repeat (2) @(posedge mclk_i);
    chk(irq, 1'b1);
    wb(1'b0, REG_IRQ_STATUS, 32'h0, 4'hf);
    chk(q & 32'h1, 32'h1);
    repeat (2) @(posedge mclk_i);
    chk(irq, 1'b0);
    // two-stage start then lock on the zero-cross inputs
    n = 0;
    do begin repeat (200) @(posedge mclk_i); wb(1'b0, REG_STATUS, 32'h0, 4'hf); n++; end
      while (q[2:0] !== 3'h3 && n < 300);
    chk(q & 32'h7, 32'h3);
    wb(1'b0, REG_IRQ_STATUS, 32'h0, 4'hf);
    chk(q & 32'h4, 32'h4);
    for (int j = 0; j < 7; j++)
    begin
      gate_move();
      for (int i = 0; i < 6; i++)
        if (br.gate === PATS[6*i +: 6]) n = i;
      if (j > 0) chk(n, (q + 1) % 6);
      q = n;
    end
    // overcurrent: gates off, stay stopped until a fresh run
    flt_b <= 1'b0;
    repeat (5) @(posedge mclk_i);
    chk(br.gate, 6'h00);
    wb(1'b0, REG_STATUS, 32'h0, 4'hf);
    chk(q & 32'h7, 32'h4);
    flt_b <= 1'b1;
    repeat (700) @(posedge mclk_i);
    chk(br.gate, 6'h00);
    // reversed order after a new run
    run <= 1'b0;
    dir <= 1'b0;
    repeat (8) @(posedge mclk_i);
    run <= 1'b1;
    gate_move();
    chk(br.gate, 6'h21);
    gate_move();
    chk(br.gate, 6'h24);
    end_sim();
  end
endmodule : sensorless_bldc_commutation_tb
